// *** rtl/ivr_map.vh ***
// register offsets, field positions, reset values and timing counts of the vector relocation block
`ifndef IVR_MAP_VH
`define IVR_MAP_VH
`define IVR_GIC_OFFSET 12'h000
`define IVR_STATUS_OFFSET 12'h004
`define IVR_GIC_RESET 8'h00
`define IVR_BIT_UNLOCK 0
`define IVR_BIT_BASE_SEL 1
`define IVR_BIT_IRQ_EN_2 5
`define IVR_BIT_IRQ_EN_0 6
`define IVR_BIT_IRQ_EN_1 7
`define IVR_GIC_WMASK 8'hE3
`define IVR_UNLOCK_CYCLES 4
`define IVR_VEC_TABLE_FIRST 16'h0002
`define IVR_VEC_TABLE_LAST 16'h0028
`define IVR_VEC_SPACING 16'h0002
`define IVR_FLASH_WORDS 16'h2000
`endif

// *** rtl/ivr_ahb_slave.v ***
// ahb-lite slave front end: captures the address phase, reports one write or read strobe
`timescale 1ns/1ps
module ivr_ahb_slave
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  // register side
  output reg wr_q,
  output reg rd_q,
  output reg [11:0] addr_q
);
  // --------------------------------------------------------------
  // address phase capture
  // --------------------------------------------------------------
  wire take;
  assign take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      // writes finish in one data cycle; reads take one wait state so hrdata is
      // loaded after any write that ended with the read's address phase
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take)
        addr_q <= haddr[11:0];
      hreadyout <= ~(take & ~hwrite);
      hresp <= 1'b0;
    end
  end
endmodule // ivr_ahb_slave

// *** rtl/ivr_unlock_timer.v ***
// unlock window timer: counts the cycles after the unlock bit is set
`timescale 1ns/1ps
module ivr_unlock_timer
#(
  parameter WINDOW = 4
)
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire start,
  input wire stop,
  // state
  output wire open,
  output wire expired
);
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  // --------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------
  always @*
  begin
    cnt_d = cnt_q;
    if (start)
      cnt_d = WINDOW[3:0];
    else if (stop)
      cnt_d = 4'h0;
    else if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end

  assign open = (cnt_q != 4'h0);
  assign expired = (cnt_q == 4'h1) & ~start & ~stop;
endmodule // ivr_unlock_timer

// *** rtl/ivr_top.v ***
// interrupt vector relocation: vector base select, timed unlock, boot-lock gating
`timescale 1ns/1ps
`include "ivr_map.vh"

module ivr_top
#(
  parameter UNLOCK_CYCLES = `IVR_UNLOCK_CYCLES
)
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // fuses and lock bits, static straps (0 = programmed)
  input wire boot_reset_fuse,
  input wire [1:0] boot_size_fuses,
  input wire application_side_lock_bit,
  input wire boot_side_lock_bit,
  // core side
  input wire [15:0] fetch_pc,
  input wire instr_done,
  input wire [5:0] vector_index,
  input wire global_irq_enable,
  // to core
  output reg [15:0] reset_address_q,
  output reg [15:0] vector_address_q,
  output reg [15:0] vector_base_q,
  output reg irq_dispatch_allow_q,
  output reg [2:0] external_irq_enable_q
);
  // --------------------------------------------------------------
  // bus front end
  // --------------------------------------------------------------
  wire wr;
  wire rd;
  wire [11:0] addr;

  ivr_ahb_slave u_slave
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_q(wr),
    .rd_q(rd),
    .addr_q(addr)
  );

  // boot area start in words from the size fuses
  function [15:0] boot_start;
    input [1:0] sz;
    begin
      case (sz)
        2'b11: boot_start = `IVR_FLASH_WORDS - 16'h0080;
        2'b10: boot_start = `IVR_FLASH_WORDS - 16'h0100;
        2'b01: boot_start = `IVR_FLASH_WORDS - 16'h0200;
        default: boot_start = `IVR_FLASH_WORDS - 16'h0400;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  reg base_sel_q;
  reg [2:0] irq_en_q;
  reg hold_q;
  reg post_write_q;
  wire gic_wr;
  wire [7:0] wdat;
  wire unlock_open;
  wire unlock_expired;
  wire unlock_set;
  wire sel_write;

  assign gic_wr = wr & (addr == `IVR_GIC_OFFSET);
  assign wdat = hwdata[7:0];
  // a set of the unlock bit is only a new sequence if none is open
  assign unlock_set = gic_wr & wdat[`IVR_BIT_UNLOCK] & ~unlock_open;
  // select write counts only inside the window with unlock written zero
  assign sel_write = gic_wr & unlock_open & ~wdat[`IVR_BIT_UNLOCK];

  ivr_unlock_timer #(.WINDOW(UNLOCK_CYCLES)) u_timer
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(unlock_set),
    .stop(sel_write),
    .open(unlock_open),
    .expired(unlock_expired)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      base_sel_q <= 1'b0;
      irq_en_q <= 3'b000;
      post_write_q <= 1'b0;
    end
    else
    begin
      if (sel_write)
        base_sel_q <= wdat[`IVR_BIT_BASE_SEL];
      if (gic_wr)
        irq_en_q <= {wdat[`IVR_BIT_IRQ_EN_1], wdat[`IVR_BIT_IRQ_EN_0],
                     wdat[`IVR_BIT_IRQ_EN_2]};
      // keep blocking until the instruction after the select write retires
      if (sel_write)
        post_write_q <= 1'b1;
      else if (instr_done)
        post_write_q <= 1'b0;
    end
  end

  always @*
    hold_q = unlock_open | post_write_q;

  // --------------------------------------------------------------
  // vector placement
  // --------------------------------------------------------------
  wire [15:0] boot_base;
  wire [15:0] vec_base;
  wire in_boot;
  wire lock_mute;
  assign boot_base = boot_start(boot_size_fuses);
  assign vec_base = base_sel_q ? boot_base : 16'h0000;
  assign in_boot = (fetch_pc >= boot_base);
  // lock bits are active low (programmed = 0)
  assign lock_mute = (base_sel_q & ~application_side_lock_bit & ~in_boot) |
                     (~base_sel_q & ~boot_side_lock_bit & in_boot);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_address_q <= 16'h0000;
      vector_address_q <= 16'h0000;
      vector_base_q <= 16'h0000;
      irq_dispatch_allow_q <= 1'b0;
      external_irq_enable_q <= 3'b000;
    end
    else
    begin
      reset_address_q <= boot_reset_fuse ? 16'h0000 : boot_base;
      vector_base_q <= vec_base;
      vector_address_q <= vec_base + ({10'h000, vector_index} * `IVR_VEC_SPACING);
      // the core's global enable is only read here, never written
      irq_dispatch_allow_q <= global_irq_enable & ~hold_q & ~unlock_set
                              & ~sel_write & ~lock_mute;
      external_irq_enable_q <= irq_en_q;
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd && addr == `IVR_GIC_OFFSET)
      hrdata <= {24'h000000, irq_en_q[2], irq_en_q[1], irq_en_q[0], 3'b000,
                 base_sel_q, unlock_open};
    else if (rd && addr == `IVR_STATUS_OFFSET)
      hrdata <= {30'h00000000, unlock_expired, hold_q};
    else if (rd)
      hrdata <= 32'h00000000;
  end
endmodule // ivr_top

// *** sim/ivr_core_model.sv ***
// core-side model: fetch address, vector number and instruction retire pulses
`timescale 1ns/1ps
module ivr_core_model
(
  // clock
  input wire hclk,
  // bench commands
  input wire [15:0] pc_cmd,
  input wire [5:0] vec_cmd,
  // to block
  output reg [15:0] fetch_pc = 16'h0000,
  output reg instr_done = 1'b0,
  output reg [5:0] vector_index = 6'h00,
  output wire global_irq_enable
);
  reg [1:0] ph_q = 2'h0;
  // i-bit held set so any automatic block shows only on the dispatch output
  assign global_irq_enable = 1'b1;
  always @(posedge hclk)
  begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    instr_done <= (ph_q == 2'h2);
    fetch_pc <= pc_cmd;
    vector_index <= vec_cmd;
  end
endmodule // ivr_core_model

// *** sim/ivr_top_props.sv ***
// port checker of the vector relocation block
`timescale 1ns/1ps
module ivr_top_props
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // inputs
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire boot_reset_fuse,
  input wire [1:0] boot_size_fuses,
  input wire application_side_lock_bit,
  input wire boot_side_lock_bit,
  input wire [15:0] fetch_pc,
  input wire [5:0] vector_index,
  // outputs
  input wire [15:0] reset_address_q,
  input wire [15:0] vector_address_q,
  input wire [15:0] vector_base_q,
  input wire irq_dispatch_allow_q
);
  reg w_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // control register write in its data phase
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      w_q <= 1'b0;
    else if (hready)
      w_q <= hsel && htrans[1] && hwrite && haddr[11:0] == 12'h000;
  a_reset_boot: assert property (
    !boot_reset_fuse && boot_size_fuses == 2'b00 |=> reset_address_q == 16'h1C00)
    else $error("reset entry off");
  a_reset_zero: assert property (
    boot_reset_fuse |=> reset_address_q == 16'h0000) else $error("reset entry not zero");
  a_base_places: assert property (
    vector_base_q == 16'h0000 || vector_base_q == 16'h2000 - (16'h0400 >> $past(boot_size_fuses)))
    else $error("bad base");
  a_vector_sum: assert property (
    $stable(vector_index) && $stable(vector_base_q)
    |-> vector_address_q == vector_base_q + {vector_index, 1'b0}) else $error("bad vector");
  a_app_mute: assert property (
    $stable(vector_base_q) && vector_base_q != 16'h0 && !application_side_lock_bit
    && fetch_pc < vector_base_q |=> !irq_dispatch_allow_q) else $error("app not muted");
  a_boot_mute: assert property (
    $stable(vector_base_q) && vector_base_q == 16'h0 && !boot_side_lock_bit
    && fetch_pc >= 16'h2000 - (16'h0400 >> boot_size_fuses) |=> !irq_dispatch_allow_q)
    else $error("boot not muted");
  a_unlock_blocks: assert property (
    w_q && hwdata[0] |=> !irq_dispatch_allow_q [*4]) else $error("unlock not blocking");
  a_base_by_write: assert property (
    $changed(vector_base_q) && $past(boot_size_fuses) == $past(boot_size_fuses, 2)
    |-> $past(w_q) || $past(w_q, 2) || $past(w_q, 3))
    else $error("base moved alone");
endmodule // ivr_top_props

// *** sim/tb_top.sv ***
// testbench of the vector relocation block
`timescale 1ns/1ps
module tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, boot_reset_fuse = 1'b0;
  logic application_side_lock_bit = 1'b1, boot_side_lock_bit = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [15:0] pc_cmd = 16'h0100;
  logic [5:0] vec_cmd = 6'h00;
  logic [1:0] boot_size_fuses = 2'b00;
  wire hready, hresp, instr_done, global_irq_enable, irq_dispatch_allow_q;
  wire [31:0] hrdata;
  wire [15:0] fetch_pc, reset_address_q, vector_address_q, vector_base_q;
  wire [5:0] vector_index;
  wire [2:0] external_irq_enable_q;
  int bad_count = 0, checked = 0;
  always #5 hclk = ~hclk;
  ivr_core_model u_ivr_core_model (.hclk, .pc_cmd, .vec_cmd, .fetch_pc, .instr_done,
    .vector_index, .global_irq_enable);
  ivr_top u_ivr_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .boot_reset_fuse,
    .boot_size_fuses, .application_side_lock_bit, .boot_side_lock_bit, .fetch_pc,
    .instr_done, .vector_index, .global_irq_enable, .reset_address_q, .vector_address_q,
    .vector_base_q, .irq_dispatch_allow_q, .external_irq_enable_q);
  task automatic give_verdict;
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    r = hrdata;
    if (n >= 20)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 8'h00, r);
    cmp(r, e);
    cmp(32'(hresp), 32'h0);
  endtask
  task automatic t_refused;
    rd(12'h000, 32'h0);
    cmp(32'(reset_address_q), 32'h1C00);
    wr(12'h000, 8'hE6);
    rd(12'h000, 32'hE0);
    cmp(32'(external_irq_enable_q), 32'h7);
    rd(12'h010, 32'h0);
  endtask
  task automatic t_lapse;
    wr(12'h000, 8'h01);
    rd(12'h004, 32'h1);
    cmp(32'(irq_dispatch_allow_q), 32'h0);
    cyc(8);
    cmp(32'(irq_dispatch_allow_q), 32'h1);
    rd(12'h000, 32'h0);
  endtask
  task automatic t_move;
    wr(12'h000, 8'h01);
    wr(12'h000, 8'h02);
    rd(12'h000, 32'h2);
    cmp(32'(vector_base_q), 32'h1C00);
    vec_cmd <= 6'd1;
    cyc(3);
    cmp(32'(vector_address_q), 32'h1C02);
    vec_cmd <= 6'd20;
    cyc(3);
    cmp(32'(vector_address_q), 32'h1C28);
    boot_size_fuses <= 2'b01;
    cyc(3);
    cmp(32'(vector_base_q), 32'h1E00);
    boot_size_fuses <= 2'b11;
    cyc(3);
    cmp(32'(vector_base_q), 32'h1F80);
    boot_size_fuses <= 2'b00;
    cyc(3);
  endtask
  task automatic t_locks;
    application_side_lock_bit <= 1'b0;
    cyc(4);
    cmp(32'(irq_dispatch_allow_q), 32'h0);
    application_side_lock_bit <= 1'b1;
    wr(12'h000, 8'h01);
    wr(12'h000, 8'h00);
    boot_side_lock_bit <= 1'b0;
    pc_cmd <= 16'h1C10;
    cyc(4);
    cmp(32'(irq_dispatch_allow_q), 32'h0);
    cmp(32'(vector_base_q), 32'h0);
    boot_side_lock_bit <= 1'b1;
    cyc(8);
    cmp(32'(irq_dispatch_allow_q), 32'h1);
    boot_reset_fuse <= 1'b1;
    cyc(3);
    cmp(32'(reset_address_q), 32'h0);
  endtask
  initial
  begin
    cyc(20);
    hresetn <= 1'b1;
    t_refused();
    t_lapse();
    t_move();
    t_locks();
    give_verdict();
  end
endmodule // tb_top
bind ivr_top ivr_top_props u_ivr_top_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .boot_reset_fuse, .boot_size_fuses, .application_side_lock_bit,
  .boot_side_lock_bit, .fetch_pc, .vector_index, .reset_address_q, .vector_address_q,
  .vector_base_q, .irq_dispatch_allow_q);
